// File: pkg/cod_pkg.sv
// constants, opcodes, register map and state types of the opcode decoder
package cod_pkg;

   // processor control opcodes, single-byte except the range check
   localparam logic [7:0] OP_CLR_CARRY = 8'hf8;
   localparam logic [7:0] OP_INV_CARRY = 8'hf5;
   localparam logic [7:0] OP_SET_CARRY = 8'hf9;
   localparam logic [7:0] OP_CLR_DIR = 8'hfc;
   localparam logic [7:0] OP_SET_DIR = 8'hfd;
   localparam logic [7:0] OP_MASK_INT = 8'hfa;
   localparam logic [7:0] OP_UNMASK_INT = 8'hfb;
   localparam logic [7:0] OP_HALT = 8'hf4;
   localparam logic [7:0] OP_WAIT = 8'h9b;
   localparam logic [7:0] OP_LOCK = 8'hf0;
   localparam logic [7:0] OP_NOP = 8'h90;
   localparam logic [7:0] OP_RET_INT = 8'hcf;
   localparam logic [7:0] OP_BOUND = 8'h62;
   // segment override prefix 001rr110
   localparam logic [7:0] SEG_PFX_MASK = 8'he7;
   localparam logic [7:0] SEG_PFX_VAL = 8'h26;

   // clock counts
   localparam logic [7:0] CLK_FLAG = 8'h02;
   localparam logic [7:0] CLK_HALT = 8'h02;
   localparam logic [7:0] CLK_WAIT = 8'h06;
   localparam logic [7:0] CLK_NOP = 8'h03;
   localparam logic [7:0] CLK_LOCK = 8'h02;
   localparam logic [7:0] CLK_SEG_PFX = 8'h02;
   localparam logic [7:0] CLK_RET_INT = 8'h1c;
   localparam logic [7:0] CLK_BOUND = 8'h21;
   localparam logic [7:0] CLK_UNKNOWN = 8'h02;
   localparam logic [7:0] WORD_XFER_CLKS = 8'h04;
   localparam logic [7:0] BOUND_XFERS = 8'h02;
   localparam logic [7:0] BOUND_WORD_ADD = 8'(WORD_XFER_CLKS * BOUND_XFERS);
   localparam logic [2:0] EA_CLKS = 3'h4;

   // addressing-kind, operand-select and segment codes
   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8 = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] RM_DIRECT = 3'h6;
   localparam logic [2:0] RM_DI_ONLY = 3'h5;
   localparam logic [1:0] SEG_EXTRA = 2'h0;
   localparam logic [1:0] SEG_CODE = 2'h1;
   localparam logic [1:0] SEG_STACK = 2'h2;
   localparam logic [1:0] SEG_DATA = 2'h3;

   // wishbone register byte offsets
   localparam logic [7:0] ADR_BASE_REG = 8'h00;
   localparam logic [7:0] ADR_BASE_PTR = 8'h04;
   localparam logic [7:0] ADR_SRC_IDX = 8'h08;
   localparam logic [7:0] ADR_DEST_IDX = 8'h0c;
   localparam logic [7:0] ADR_CTRL = 8'h10;
   localparam logic [7:0] ADR_STATUS = 8'h14;
   localparam logic [7:0] ADR_ADDR = 8'h18;
   localparam logic [7:0] ADR_REGSEL = 8'h1c;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_MODRM = 3'b001,
      S_DLO = 3'b010,
      S_DHI = 3'b011,
      S_EXEC = 3'b100,
      S_PFX = 3'b101
   } cod_state_t;

   typedef struct packed {
      logic [1:0] kind;
      logic [2:0] regf;
      logic [2:0] sel;
   } cod_modrm_t;

   typedef struct packed {
      logic wide;
      logic hi_byte;
      logic [2:0] idx;
   } cod_reg_sel_t;

   typedef struct packed {
      cod_state_t state;
      logic [7:0] cnt;
      logic [2:0] ea_cnt;
      logic [7:0] total;
      logic [7:0] opcode;
      cod_modrm_t modrm;
      logic [15:0] disp;
      logic lock;
      logic ovr;
      logic [1:0] ovr_seg;
      logic carry;
      logic dir;
      logic ie;
      logic unknown;
      logic [15:0] bx;
      logic [15:0] bp;
      logic [15:0] si;
      logic [15:0] di;
      logic word_op;
      logic str_dest;
      logic [15:0] ea;
      logic [1:0] seg;
      logic ea_valid;
      logic done;
      logic ready;
      logic ack;
      logic [31:0] rdat;
   } cod_st_t;

   localparam cod_st_t COD_ST_RST = '0;

endpackage

// File: rtl/cod_reg_dec.sv
// register field decoder: word register or byte half
`timescale 1ns/1ps
module cod_reg_dec import cod_pkg::*; (
   input wire logic [2:0] field_i,
   input wire logic wide_i,
   output cod_reg_sel_t sel_o
);
   always_comb begin
      sel_o.wide = wide_i;
      if (wide_i) begin
         sel_o.idx = field_i; // RL15
         sel_o.hi_byte = 1'b0;
      end else begin
         // byte halves live in the first four word registers
         sel_o.idx = {1'b0, field_i[1:0]}; // RL15
         sel_o.hi_byte = field_i[2];
      end
   end
endmodule

// File: rtl/cod_ea_unit.sv
// operand address adder and segment selection
`timescale 1ns/1ps
module cod_ea_unit import cod_pkg::*; (
   input wire cod_modrm_t modrm_i,
   input wire logic [15:0] base_reg_word_i,
   input wire logic [15:0] base_pointer_i,
   input wire logic [15:0] src_index_i,
   input wire logic [15:0] dest_index_i,
   input wire logic [15:0] disp_i,
   input wire logic ovr_valid_i,
   input wire logic [1:0] ovr_seg_i,
   input wire logic string_dest_i,
   output logic [15:0] operand_address_o,
   output logic [1:0] seg_o
);
   logic [15:0] base;
   logic uses_bp;

   always_comb begin
      uses_bp = 1'b0;
      case (modrm_i.sel) // RL10
         3'h0: base = base_reg_word_i + src_index_i;
         3'h1: base = base_reg_word_i + dest_index_i;
         3'h2: begin
            base = base_pointer_i + src_index_i;
            uses_bp = 1'b1;
         end
         3'h3: begin
            base = base_pointer_i + dest_index_i;
            uses_bp = 1'b1;
         end
         3'h4: base = src_index_i;
         3'h5: base = dest_index_i;
         3'h6: begin
            base = base_pointer_i;
            uses_bp = 1'b1;
         end
         default: base = base_reg_word_i;
      endcase
      if (modrm_i.kind == MOD_NODISP && modrm_i.sel == RM_DIRECT) begin
         base = 16'h0000; // RL11
         uses_bp = 1'b0;
      end
      operand_address_o = base + disp_i; // RL10
      if (string_dest_i && modrm_i.sel == RM_DI_ONLY) begin
         seg_o = SEG_EXTRA; // RL17
      end else if (ovr_valid_i) begin
         seg_o = ovr_seg_i; // RL14
      end else if (uses_bp) begin
         seg_o = SEG_STACK; // RL16
      end else begin
         seg_o = SEG_DATA;
      end
   end
endmodule

// File: rtl/cod_opcode_ea_dec.sv
// processor control opcode decoder with operand address unit
`timescale 1ns/1ps
// How it works
// RL1 - carry clear, invert, set take two clocks
// RL2 - direction clear and set take two clocks
// RL3 - interrupt mask and unmask take two clocks
// RL4 - lock prefix two clocks, locks next instruction
// RL5 - interrupt return takes twenty-eight clocks
// RL6 - range check with addressing byte, 33-35 clocks
// RL7 - word operations add four per transfer
// RL8 - kind 11 makes operand-select a register
// RL9 - kind picks zero, short or long displacement
// RL10 - address from operand-select sum plus displacement
// RL11 - kind 00 select 110 is direct
// RL12 - displacement follows second byte, before immediates
// RL13 - address takes four clocks inside counts
// RL14 - prefix 001rr110 overrides operand segment
// RL15 - register field decode by width bit
// RL16 - base pointer operands default to stack
// RL17 - string destination always uses extra segment; code forces it only when operand-select is 101 (destination index alone)
// RL18 - prefixes cleared when next instruction completes
module cod_opcode_ea_dec import cod_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] byte_i,
   input wire logic byte_valid_i,
   output logic byte_ready_o,
   output logic instr_done_o,
   output logic addr_valid_o,
   output logic [15:0] operand_address_o,
   output logic [1:0] seg_sel_o,
   output logic bus_lock_o,
   output logic carry_flag_o,
   output logic dir_flag_o,
   output logic int_enable_o
);
   cod_st_t st_reg;
   cod_st_t st_next;
   cod_reg_sel_t regf_sel;
   cod_reg_sel_t rmf_sel;
   cod_modrm_t go_modrm;
   logic [15:0] ea_w;
   logic [1:0] seg_w;
   logic [8:0] info;
   logic take;
   logic go_bound;
   logic [7:0] h_cyc_reg;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] dat,
                                           input logic [1:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) r[7:0] = dat[7:0];
      if (sel[1]) r[15:8] = dat[15:8];
      return r;
   endfunction

   // {known, clocks} of a single-byte instruction
   function automatic logic [8:0] op_info(input logic [7:0] op);
      case (op)
         OP_CLR_CARRY, OP_INV_CARRY, OP_SET_CARRY: op_info = {1'b1, CLK_FLAG};
         OP_CLR_DIR, OP_SET_DIR: op_info = {1'b1, CLK_FLAG};
         OP_MASK_INT, OP_UNMASK_INT: op_info = {1'b1, CLK_FLAG};
         OP_HALT: op_info = {1'b1, CLK_HALT};
         OP_WAIT: op_info = {1'b1, CLK_WAIT};
         OP_NOP: op_info = {1'b1, CLK_NOP};
         OP_RET_INT: op_info = {1'b1, CLK_RET_INT};
         default: op_info = {1'b0, CLK_UNKNOWN};
      endcase
   endfunction

   function automatic logic [7:0] bound_clks(input cod_modrm_t m,
                                             input logic w);
      logic [7:0] c;
      c = CLK_BOUND;
      if (m.kind == MOD_DISP8) begin
         c = c + 8'h01; // RL6
      end else if (m.kind == MOD_DISP16 ||
                   (m.kind == MOD_NODISP && m.sel == RM_DIRECT)) begin
         c = c + 8'h02; // RL6
      end
      if (w) c = c + BOUND_WORD_ADD; // RL7
      return c;
   endfunction

   cod_reg_dec u_regf (
      .field_i(st_reg.modrm.regf),
      .wide_i(st_reg.word_op),
      .sel_o(regf_sel)
   );

   cod_reg_dec u_rmf (
      .field_i(st_reg.modrm.sel),
      .wide_i(st_reg.word_op),
      .sel_o(rmf_sel)
   );

   cod_ea_unit u_ea (
      .modrm_i(st_reg.modrm),
      .base_reg_word_i(st_reg.bx),
      .base_pointer_i(st_reg.bp),
      .src_index_i(st_reg.si),
      .dest_index_i(st_reg.di),
      .disp_i(st_reg.disp),
      .ovr_valid_i(st_reg.ovr),
      .ovr_seg_i(st_reg.ovr_seg),
      .string_dest_i(st_reg.str_dest),
      .operand_address_o(ea_w),
      .seg_o(seg_w)
   );

   assign take = byte_valid_i && st_reg.ready;
   assign info = op_info(byte_i);

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.ea_valid = 1'b0;
      st_next.ack = 1'b0;
      go_bound = 1'b0;
      go_modrm = st_reg.modrm;

      // classic wishbone slave, one wait state, unmapped reads as zero
      if (wb_cyc_i && wb_stb_i && !st_reg.ack) begin
         st_next.ack = 1'b1;
         st_next.rdat = 32'h00000000;
         if (wb_adr_i[7:2] == ADR_BASE_REG[7:2]) begin
            st_next.rdat = {16'h0000, st_reg.bx};
            if (wb_we_i) begin
               st_next.bx = merge16(st_reg.bx, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
         end else if (wb_adr_i[7:2] == ADR_BASE_PTR[7:2]) begin
            st_next.rdat = {16'h0000, st_reg.bp};
            if (wb_we_i) begin
               st_next.bp = merge16(st_reg.bp, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
         end else if (wb_adr_i[7:2] == ADR_SRC_IDX[7:2]) begin
            st_next.rdat = {16'h0000, st_reg.si};
            if (wb_we_i) begin
               st_next.si = merge16(st_reg.si, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
         end else if (wb_adr_i[7:2] == ADR_DEST_IDX[7:2]) begin
            st_next.rdat = {16'h0000, st_reg.di};
            if (wb_we_i) begin
               st_next.di = merge16(st_reg.di, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
         end else if (wb_adr_i[7:2] == ADR_CTRL[7:2]) begin
            st_next.rdat = {30'h00000000, st_reg.str_dest, st_reg.word_op};
            if (wb_we_i && wb_sel_i[0]) begin
               st_next.word_op = wb_dat_i[0];
               st_next.str_dest = wb_dat_i[1];
            end
         end else if (wb_adr_i[7:2] == ADR_STATUS[7:2]) begin
            st_next.rdat = {13'h0000, st_reg.ovr_seg, st_reg.ovr,
                            st_reg.opcode, st_reg.state != S_IDLE,
                            st_reg.unknown, st_reg.seg, st_reg.lock,
                            st_reg.ie, st_reg.dir, st_reg.carry};
         end else if (wb_adr_i[7:2] == ADR_ADDR[7:2]) begin
            st_next.rdat = {14'h0000, st_reg.seg, st_reg.ea};
         end else if (wb_adr_i[7:2] == ADR_REGSEL[7:2]) begin
            st_next.rdat = {8'h00, st_reg.total, 5'h00,
                            st_reg.modrm.kind == MOD_REG, rmf_sel,
                            regf_sel}; // RL8
         end
      end

      case (st_reg.state)
         S_IDLE: begin
            st_next.ready = 1'b1;
            if (take) begin
               st_next.opcode = byte_i;
               st_next.unknown = 1'b0;
               if (byte_i == OP_LOCK) begin
                  st_next.state = S_PFX;
                  st_next.cnt = CLK_LOCK - 8'h01; // RL4
                  st_next.ready = 1'b0;
               end else if ((byte_i & SEG_PFX_MASK) == SEG_PFX_VAL) begin
                  st_next.state = S_PFX; // RL14
                  st_next.cnt = CLK_SEG_PFX - 8'h01;
                  st_next.ready = 1'b0;
               end else if (byte_i == OP_BOUND) begin
                  st_next.state = S_MODRM; // RL6
               end else begin
                  st_next.state = S_EXEC;
                  st_next.total = info[7:0];
                  st_next.cnt = info[7:0] - 8'h01; // RL1 RL2 RL3 RL5
                  st_next.ea_cnt = 3'h0;
                  st_next.unknown = !info[8];
                  st_next.ready = 1'b0;
               end
            end
         end
         S_PFX: begin
            if (st_reg.cnt == 8'h01) begin
               st_next.state = S_IDLE;
               st_next.ready = 1'b1;
               if (st_reg.opcode == OP_LOCK) begin
                  st_next.lock = 1'b1; // RL4
               end else begin
                  st_next.ovr = 1'b1; // RL14
                  st_next.ovr_seg = st_reg.opcode[4:3];
               end
            end else begin
               st_next.cnt = st_reg.cnt - 8'h01;
            end
         end
         S_MODRM: begin
            if (take) begin
               st_next.modrm = byte_i;
               st_next.disp = 16'h0000; // RL9
               go_modrm = byte_i;
               // displacement bytes come right after this byte
               if (byte_i[7:6] == MOD_REG) begin
                  go_bound = 1'b1; // RL8
               end else if (byte_i[7:6] == MOD_NODISP &&
                            byte_i[2:0] != RM_DIRECT) begin
                  go_bound = 1'b1; // RL9
               end else begin
                  st_next.state = S_DLO; // RL12
               end
            end
         end
         S_DLO: begin
            if (take) begin
               st_next.disp = {{8{byte_i[7]}}, byte_i}; // RL9
               if (st_reg.modrm.kind == MOD_DISP8) begin
                  go_bound = 1'b1;
               end else begin
                  st_next.state = S_DHI;
               end
            end
         end
         S_DHI: begin
            if (take) begin
               st_next.disp[15:8] = byte_i; // RL9
               go_bound = 1'b1;
            end
         end
         S_EXEC: begin
            if (st_reg.ea_cnt != 3'h0) begin
               st_next.ea_cnt = st_reg.ea_cnt - 3'h1;
               if (st_reg.ea_cnt == 3'h1) begin
                  st_next.ea = ea_w; // RL13
                  st_next.seg = seg_w;
                  st_next.ea_valid = 1'b1;
               end
            end
            if (st_reg.cnt == 8'h01) begin
               st_next.state = S_IDLE;
               st_next.ready = 1'b1;
               st_next.done = 1'b1;
               st_next.lock = 1'b0; // RL18
               st_next.ovr = 1'b0; // RL18
               case (st_reg.opcode)
                  OP_CLR_CARRY: st_next.carry = 1'b0; // RL1
                  OP_INV_CARRY: st_next.carry = !st_reg.carry; // RL1
                  OP_SET_CARRY: st_next.carry = 1'b1; // RL1
                  OP_CLR_DIR: st_next.dir = 1'b0; // RL2
                  OP_SET_DIR: st_next.dir = 1'b1; // RL2
                  OP_MASK_INT: st_next.ie = 1'b0; // RL3
                  OP_UNMASK_INT: st_next.ie = 1'b1; // RL3
                  default: ;
               endcase
            end else begin
               st_next.cnt = st_reg.cnt - 8'h01;
            end
         end
         default: st_next.state = S_IDLE;
      endcase

      // the address phase is part of the range-check count, not added
      if (go_bound) begin
         st_next.state = S_EXEC;
         st_next.ready = 1'b0;
         st_next.total = bound_clks(go_modrm, st_reg.word_op); // RL6 RL7
         st_next.cnt = st_next.total - 8'h01;
         st_next.ea_cnt = (go_modrm.kind == MOD_REG) ? 3'h0 : EA_CLKS; // RL13
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= COD_ST_RST;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o = st_reg.rdat;
   assign wb_ack_o = st_reg.ack;
   assign byte_ready_o = st_reg.ready;
   assign instr_done_o = st_reg.done;
   assign addr_valid_o = st_reg.ea_valid;
   assign operand_address_o = st_reg.ea;
   assign seg_sel_o = st_reg.seg;
   assign bus_lock_o = st_reg.lock;
   assign carry_flag_o = st_reg.carry;
   assign dir_flag_o = st_reg.dir;
   assign int_enable_o = st_reg.ie;

   // enabled clocks since the instruction entered execution
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         h_cyc_reg <= 8'h00;
      end else if (ce_i) begin
         if (st_next.state == S_EXEC && st_reg.state != S_EXEC) begin
            h_cyc_reg <= 8'h01;
         end else if (st_reg.state != S_IDLE) begin
            h_cyc_reg <= h_cyc_reg + 8'h01;
         end
      end
   end

   a_carry_timing: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
      instr_done_o && st_reg.opcode == OP_SET_CARRY
      |-> carry_flag_o && h_cyc_reg == 8'h02)
      else $error("set carry wrong value or clock count");
   a_dir_timing: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      instr_done_o && st_reg.opcode == OP_SET_DIR
      |-> dir_flag_o && h_cyc_reg == 8'h02)
      else $error("set direction wrong value or clock count");
   a_int_mask: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
      instr_done_o && st_reg.opcode == OP_MASK_INT
      |-> !int_enable_o && h_cyc_reg == 8'h02)
      else $error("interrupt mask wrong value or clock count");
   a_lock_set: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
      ce_i && st_reg.state == S_PFX && st_reg.opcode == OP_LOCK &&
      st_reg.cnt == 8'h01 |=> bus_lock_o && byte_ready_o)
      else $error("lock prefix did not lock after two clocks");
   a_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
      $fell(bus_lock_o) |-> instr_done_o)
      else $error("bus lock dropped before instruction end");
   a_prefix_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
      instr_done_o |-> !bus_lock_o && !st_reg.ovr)
      else $error("prefix effect survived its instruction");
   a_ret_timing: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
      instr_done_o && st_reg.opcode == OP_RET_INT |-> h_cyc_reg == 8'h1c)
      else $error("interrupt return not 28 clocks");
   a_bound_timing: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
      instr_done_o && st_reg.opcode == OP_BOUND && !st_reg.word_op
      |-> h_cyc_reg >= 8'h21 && h_cyc_reg <= 8'h23)
      else $error("range check outside 33 to 35 clocks");
   a_word_add: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
      instr_done_o && st_reg.opcode == OP_BOUND && st_reg.word_op &&
      st_reg.modrm.kind == MOD_DISP8 |-> h_cyc_reg == 8'h2a)
      else $error("word range check missing transfer clocks");
   a_reg_operand: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
      st_reg.state == S_EXEC && st_reg.modrm.kind == MOD_REG &&
      st_reg.opcode == OP_BOUND |-> !addr_valid_o)
      else $error("register operand produced a memory address");
   a_disp_sign: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      addr_valid_o && st_reg.modrm.kind == MOD_DISP8
      |-> st_reg.disp[15:8] == {8{st_reg.disp[7]}})
      else $error("short displacement not sign extended");
   a_ea_sum: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
      addr_valid_o && st_reg.modrm.sel == 3'h0 && st_reg.modrm.kind != 2'h0
      |-> operand_address_o == 16'(st_reg.bx + st_reg.si + st_reg.disp))
      else $error("base plus source index address wrong");
   a_ea_direct: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
      addr_valid_o && st_reg.modrm.kind == MOD_NODISP &&
      st_reg.modrm.sel == RM_DIRECT |-> operand_address_o == st_reg.disp)
      else $error("direct address not displacement alone");
   a_disp_order: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
      ce_i && take && st_reg.state == S_MODRM && byte_i[7:6] == MOD_DISP8
      |=> st_reg.state == S_DLO && byte_ready_o)
      else $error("displacement not fetched after second byte");
   a_ea_delay: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
      addr_valid_o |-> h_cyc_reg == 8'h05 && st_reg.state == S_EXEC)
      else $error("address not ready four clocks into execution");
   a_seg_ovr: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
      addr_valid_o && st_reg.ovr && !st_reg.str_dest
      |-> seg_sel_o == st_reg.ovr_seg)
      else $error("segment override ignored");
   a_reg_byte: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
      !st_reg.word_op |-> !regf_sel.idx[2] &&
      regf_sel.hi_byte == st_reg.modrm.regf[2])
      else $error("byte register field decoded wrongly");
   a_bp_stack: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
      addr_valid_o && !st_reg.ovr && st_reg.modrm.sel == 3'h2
      |-> seg_sel_o == SEG_STACK)
      else $error("base pointer operand not in stack segment");
   a_string_es: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
      addr_valid_o && st_reg.str_dest && st_reg.modrm.sel == RM_DI_ONLY
      |-> seg_sel_o == SEG_EXTRA)
      else $error("string destination not in extra segment");
endmodule

// File: tb/cod_pq_model.sv
// prefetch queue model that feeds instruction bytes
`timescale 1ns/1ps
module cod_pq_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ready_i,
   output logic [7:0] byte_o,
   output logic valid_o
);
   logic [7:0] q[$];
   logic [7:0] last = 8'h00;
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   // an empty queue shows the inverse of the last byte, never stale data
   always @(posedge clk_i) begin
      if (rst_i) begin
         q.delete();
         valid_o <= 1'b0;
      end else begin
         if (valid_o && ready_i) begin
            last = q.pop_front();
         end
         valid_o <= q.size() != 0;
         byte_o <= (q.size() != 0) ? q[0] : ~last;
      end
   end
   initial byte_o = 8'h00;
endmodule

// File: tb/cod_opcode_ea_dec_bench.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   err_count++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module cod_opcode_ea_dec_bench;
   import cod_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, pb;
   logic [31:0] wd = 32'h0, rdat, r;
   logic ack, pv, rdy, done, av, lock, cf, df, ie;
   logic [15:0] oa;
   logic [1:0] sg;
   int err_count = 0, samples_checked = 0, i;
   logic [7:0] fop[7] = '{8'hf9, 8'hf8, 8'hf5, 8'hfd, 8'hfc, 8'hfb, 8'hfa};
   logic [2:0] fx[7] = '{3'h4, 3'h0, 3'h4, 3'h6, 3'h4, 3'h5, 3'h4};
   always #12.5 clk_i = ~clk_i;
   cod_pq_model cod_pq_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .ready_i(rdy), .byte_o(pb), .valid_o(pv));
   cod_opcode_ea_dec cod_opcode_ea_dec_inst (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(rdat),
      .wb_ack_o(ack), .byte_i(pb), .byte_valid_i(pv), .byte_ready_o(rdy),
      .instr_done_o(done), .addr_valid_o(av), .operand_address_o(oa),
      .seg_sel_o(sg), .bus_lock_o(lock), .carry_flag_o(cf),
      .dir_flag_o(df), .int_enable_o(ie));
   task automatic tally_and_finish;
      $display("checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // request held until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic exec(input logic [31:0] b, input int n);
      int k;
      for (k = 0; k < n; k++) begin
         cod_pq_model_inst.push(b[8*k+:8]);
      end
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (done !== 1'b1 && k < 200);
      `CHK(done, 1'b1)
   endtask
   task automatic tot(input logic [7:0] t);
      wb(1'b0, ADR_REGSEL, 32'h0);
      `CHK(r[23:16], t)
   endtask
   task automatic ea(input logic [1:0] c, input logic [31:0] b, input int n,
         input logic [17:0] x, input logic [7:0] t);
      wb(1'b1, ADR_CTRL, {30'h0, c});
      exec(b, n);
      wb(1'b0, ADR_ADDR, 32'h0);
      `CHK(r[17:0], x)
      `CHK({sg, oa}, x)
      if (t != 8'h00) begin
         tot(t);
      end
   endtask
   initial begin
      #(25 * 20000);
      err_count++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      wb(1'b0, ADR_BASE_REG, 32'h0);
      `CHK(r, 32'h0)
      wb(1'b0, 8'h40, 32'h0);
      `CHK(r, 32'h0)
      wb(1'b1, ADR_BASE_REG, 32'h1000);
      wb(1'b1, ADR_BASE_PTR, 32'h2000);
      wb(1'b1, ADR_SRC_IDX, 32'h20);
      wb(1'b1, ADR_DEST_IDX, 32'h300);
      for (i = 0; i < 7; i++) begin
         exec(fop[i], 1);
         `CHK({cf, df, ie}, fx[i])
         tot(8'h02);
      end
      exec(32'hcf, 1);
      tot(8'h1c);
      cod_pq_model_inst.push(8'hf0);
      repeat (6) @(posedge clk_i);
      `CHK(lock, 1'b1)
      exec(32'hf8, 1);
      repeat (2) @(posedge clk_i);
      `CHK(lock, 1'b0)
      exec(32'he162, 2);
      wb(1'b0, ADR_REGSEL, 32'h0);
      `CHK({r[10], r[4:3]}, 3'b101)
      ea(2'h0, 32'hfe4062, 3, 18'h3101e, 8'h22);
      ea(2'h0, 32'h12340662, 4, 18'h31234, 8'h23);
      ea(2'h0, 32'h108262, 4, 18'h22030, 8'h23);
      ea(2'h1, 32'h804762, 3, 18'h30f80, 8'h2a);
      ea(2'h0, 32'h026226, 3, 18'h02020, 8'h00);
      ea(2'h2, 32'h05623e, 3, 18'h00300, 8'h00);
      ea(2'h0, 32'h0262, 2, 18'h22020, 8'h00);
      tally_and_finish();
   end
endmodule
